// [ssr_config_regs.sv]
// register bank and pin steering for the synthesizer ratio and function configuration
// assumes the serial engines deliver single-cycle byte strobes synchronous to clk
module ssr_config_regs
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // byte register port from the serial engines
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic spi_mode,
    output logic [7:0] reg_rdata,
    // state held outside this bank
    input wire logic port_enable_first,
    input wire logic [1:0] aux_pin_source_sel,
    input wire logic loop_unlocked,
    // reference and synthesizer signals, sampled as levels
    input wire logic reference_in,
    input wire logic synth_clk,
    // to the synthesizer core
    output logic control_port_mode,
    output logic [31:0] user_ratio,
    output logic divided_reference,
    // pin drivers
    output logic clk_out,
    output logic aux_level,
    output logic aux_oe
);
    // stored configuration
    logic port_enable_second_r;
    logic [7:0] ratio_byte_r [4];
    logic lock_pin_style_r;
    logic [1:0] reference_prescale_sel_r;
    logic run_while_unlocked_r;
    logic ref_d_r;
    logic [1:0] ref_cnt_r;

    // address decode
    wire logic wr_global = reg_wr && (reg_addr == SSR_ADDR_GLOBAL);
    wire logic wr_func1 = reg_wr && (reg_addr == SSR_ADDR_FUNC1);
    wire logic wr_func2 = reg_wr && (reg_addr == SSR_ADDR_FUNC2);
    wire logic ref_rise = reference_in && !ref_d_r;

    // (RULE1) mode needs both enables
    assign control_port_mode = port_enable_first && port_enable_second_r;

    // (RULE2) byte 06h lands in the top bits
    assign user_ratio = {ratio_byte_r[0], ratio_byte_r[1], ratio_byte_r[2], ratio_byte_r[3]};

    // ratio bytes, one per generated slice
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ratio
            wire logic [7:0] slot_addr = SSR_ADDR_RATIO0 + 8'(gi);
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    ratio_byte_r[gi] <= SSR_RST_RATIO[31 - 8 * gi -: 8];
                end else if (reg_wr && reg_addr == slot_addr) begin
                    ratio_byte_r[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // control bits; reserved bits are not stored and read as zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            port_enable_second_r <= SSR_RST_BIT;
            lock_pin_style_r <= SSR_RST_BIT;
            reference_prescale_sel_r <= SSR_RST_PRESCALE;
            run_while_unlocked_r <= SSR_RST_BIT;
        end else begin
            if (wr_global) begin
                port_enable_second_r <= reg_wdata[SSR_POS_PORT_EN2];
            end
            // (RULE11) field placement in 16h and 17h
            if (wr_func1) begin
                lock_pin_style_r <= reg_wdata[SSR_POS_LOCK_STYLE];
                reference_prescale_sel_r <= reg_wdata[SSR_POS_PRESCALE +: 2];
            end
            if (wr_func2) begin
                run_while_unlocked_r <= reg_wdata[SSR_POS_RUN_UNL];
            end
        end
    end

    // readback mux; unmapped addresses read as zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            SSR_ADDR_GLOBAL: rd_mux[SSR_POS_PORT_EN2] = port_enable_second_r;
            SSR_ADDR_RATIO0: rd_mux = ratio_byte_r[0];
            SSR_ADDR_RATIO1: rd_mux = ratio_byte_r[1];
            SSR_ADDR_RATIO2: rd_mux = ratio_byte_r[2];
            SSR_ADDR_RATIO3: rd_mux = ratio_byte_r[3];
            SSR_ADDR_FUNC1: begin
                rd_mux[SSR_POS_LOCK_STYLE] = lock_pin_style_r;
                rd_mux[SSR_POS_PRESCALE +: 2] = reference_prescale_sel_r;
            end
            SSR_ADDR_FUNC2: rd_mux[SSR_POS_RUN_UNL] = run_while_unlocked_r;
            default: rd_mux = 8'h00;
        endcase
    end

    // (RULE12) spi reads return zero, data only over i2c
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= spi_mode ? 8'h00 : rd_mux;
        end
    end

    // reference edge counter: bit 0 toggles every rising edge, bit 1 every second
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ref_d_r <= 1'b0;
            ref_cnt_r <= 2'h0;
        end else begin
            ref_d_r <= reference_in;
            if (ref_rise) begin
                ref_cnt_r <= ref_cnt_r + 2'h1;
            end
        end
    end

    // (RULE7) prescale selection; reserved code parks the output low
    logic ref_div_nxt;
    always_comb begin
        case (reference_prescale_sel_r)
            SSR_PRE_DIV4: ref_div_nxt = ref_cnt_r[1];
            SSR_PRE_DIV2: ref_div_nxt = ref_cnt_r[0];
            SSR_PRE_DIV1: ref_div_nxt = ref_d_r;
            default: ref_div_nxt = 1'b0;
        endcase
    end

    // (RULE9) (RULE10) gating of the clock output on unlock
    wire logic clk_out_nxt = synth_clk && (run_while_unlocked_r || !loop_unlocked);

    // aux pin source and driver style
    logic aux_level_nxt;
    logic aux_oe_nxt;
    always_comb begin
        aux_oe_nxt = 1'b1;
        case (aux_pin_source_sel)
            SSR_AUX_REFDIV: aux_level_nxt = ref_div_nxt;
            SSR_AUX_SYNTH: aux_level_nxt = clk_out_nxt;
            // (RULE14) (RULE4) lock status, style applies only here
            SSR_AUX_LOCK: begin
                // (RULE5) (RULE6) push-pull high or open drain pulled low
                aux_level_nxt = lock_pin_style_r ? 1'b0 : loop_unlocked;
                aux_oe_nxt = lock_pin_style_r ? loop_unlocked : 1'b1;
            end
            default: aux_level_nxt = 1'b0;
        endcase
    end

    // pin registers, kept in flops so the pads see no decode glitches
    always_ff @(posedge clk) begin
        if (!resetn) begin
            divided_reference <= 1'b0;
            clk_out <= 1'b0;
            aux_level <= 1'b0;
            aux_oe <= 1'b0;
        end else begin
            divided_reference <= ref_div_nxt;
            clk_out <= clk_out_nxt;
            aux_level <= aux_level_nxt;
            aux_oe <= aux_oe_nxt;
        end
    end

    // checks on the bank and the pin steering
    sequence s_ratio_msb_write;
        reg_wr && reg_addr == SSR_ADDR_RATIO0;
    endsequence
    sequence s_ratio_lsb_write;
        reg_wr && reg_addr == SSR_ADDR_RATIO3;
    endsequence

    a_mode_both_bits: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        wr_global && reg_wdata[0] && port_enable_first ##1 port_enable_first
        |-> control_port_mode)
        else $error("mode not entered with both enables set");
    a_ratio_msb_byte: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        s_ratio_msb_write |=> user_ratio[31:24] == $past(reg_wdata))
        else $error("byte 06h not in ratio msb");
    a_ratio_lsb_byte: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        s_ratio_lsb_write |=> user_ratio[7:0] == $past(reg_wdata))
        else $error("byte 09h not in ratio lsb");
    a_style_field_place: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        wr_func1 ##1 !reg_wr ##1 reg_rd && !spi_mode && reg_addr == SSR_ADDR_FUNC1 && !reg_wr
        |=> reg_rdata[6] == $past(reg_wdata[6], 3) && reg_rdata[4:3] == $past(reg_wdata[4:3], 3))
        else $error("function config 1 fields misplaced");
    a_aux_clock_style: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        aux_pin_source_sel != SSR_AUX_LOCK |=> aux_oe)
        else $error("style bit affected a clock source");
    a_aux_push_pull: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        aux_pin_source_sel == SSR_AUX_LOCK && !lock_pin_style_r
        |=> aux_oe && aux_level == $past(loop_unlocked))
        else $error("push-pull unlock indicator wrong");
    a_aux_open_drain: assert property (@(posedge clk) disable iff (!resetn) // RULE6
        aux_pin_source_sel == SSR_AUX_LOCK && lock_pin_style_r
        |=> !aux_level && aux_oe == $past(loop_unlocked))
        else $error("open drain unlock indicator wrong");
    a_prescale_reserved: assert property (@(posedge clk) disable iff (!resetn) // RULE7
        reference_prescale_sel_r == 2'h3 |=> !divided_reference)
        else $error("reserved prescale produced a clock");
    a_prescale_div4: assert property (@(posedge clk) disable iff (!resetn) // RULE7
        reference_prescale_sel_r == SSR_PRE_DIV4 && ref_rise && ref_cnt_r[0]
        ##1 reference_prescale_sel_r == SSR_PRE_DIV4 |=> divided_reference != $past(divided_reference))
        else $error("divide by four did not toggle on second edge");
    a_clk_held_low: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        !run_while_unlocked_r && loop_unlocked |=> !clk_out)
        else $error("clock output ran while unlocked");
    a_clk_always_runs: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        run_while_unlocked_r |=> clk_out == $past(synth_clk))
        else $error("clock output not passed through");
    a_spi_no_readback: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        reg_rd && spi_mode |=> reg_rdata == 8'h00)
        else $error("spi read returned data");
endmodule : ssr_config_regs

// [ssr_pkg.sv]
// constants for the synthesizer ratio and function configuration registers
// assumes a serial port engine that hands over decoded byte reads and writes
// Summary of operation
// (RULE1) control port mode is entered only while both port enable bits are 1, set in any order.
// (RULE2) bytes at 06h to 09h form one 32-bit ratio, bit 7 of 06h the msb, bit 0 of 09h the lsb.
// (RULE3) the host writes the ratio as unsigned 12.20 fixed point, ratio times two to the 20.
// (RULE4) the lock pin style bit acts only when the aux source select is 11, never for a clock.
// (RULE5) style 0 drives the aux pin push-pull, high while unlocked and low while locked.
// (RULE6) style 1 makes the aux pin open drain, low while unlocked and released while locked.
// (RULE7) prescale 00 divides the reference by four, 01 by two, 10 passes it, 11 is reserved.
// (RULE8) the host picks the prescale from the reference frequency range.
// (RULE9) with run-while-unlocked at 0 the clock outputs are held low while the loop is unlocked.
// (RULE10) with run-while-unlocked at 1 the clock outputs always pass the synthesizer output.
// (RULE11) style is bit 6 and prescale bits 4:3 of 16h, run-while-unlocked is bit 4 of 17h.
// (RULE12) registers read back over i2c and are write only over spi.
// (RULE13) the host keeps reserved bits at their default values.
// (RULE14) aux source select 11 routes the unlock indicator to the aux pin instead of a clock.
package ssr_pkg;
    // register addresses
    localparam logic [7:0] SSR_ADDR_GLOBAL = 8'h05;
    localparam logic [7:0] SSR_ADDR_RATIO0 = 8'h06;
    localparam logic [7:0] SSR_ADDR_RATIO1 = 8'h07;
    localparam logic [7:0] SSR_ADDR_RATIO2 = 8'h08;
    localparam logic [7:0] SSR_ADDR_RATIO3 = 8'h09;
    localparam logic [7:0] SSR_ADDR_FUNC1 = 8'h16;
    localparam logic [7:0] SSR_ADDR_FUNC2 = 8'h17;
    // field positions
    localparam int SSR_POS_PORT_EN2 = 0;
    localparam int SSR_POS_LOCK_STYLE = 6;
    localparam int SSR_POS_PRESCALE = 3;
    localparam int SSR_POS_RUN_UNL = 4;
    // reset values
    localparam logic [31:0] SSR_RST_RATIO = 32'h0000_0000;
    localparam logic SSR_RST_BIT = 1'b0;
    localparam logic [1:0] SSR_RST_PRESCALE = 2'h0;
    // prescale and aux source encodings
    localparam logic [1:0] SSR_PRE_DIV4 = 2'h0;
    localparam logic [1:0] SSR_PRE_DIV2 = 2'h1;
    localparam logic [1:0] SSR_PRE_DIV1 = 2'h2;
    localparam logic [1:0] SSR_AUX_REFDIV = 2'h0;
    localparam logic [1:0] SSR_AUX_SYNTH = 2'h2;
    localparam logic [1:0] SSR_AUX_LOCK = 2'h3;
endpackage : ssr_pkg

// [ssr_host_model.sv]
// host controller model on the byte register port of the config bank
// assumes strobes are taken on the rising edge of clk
module ssr_host_model (
    // clock
    input wire logic clk,
    // byte register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic spi_mode,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle port, no strobe before reset is released
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        spi_mode = 1'b0;
    end
    // caller supplies encoded values
    // one access, strobe held over one taking edge, lines inverted once released
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic spi, output logic [7:0] q);
        @(posedge clk) #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        spi_mode = spi;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
    endtask : acc
endmodule : ssr_host_model

// [tb_top.sv]
// self-checking bench for the ratio and function configuration bank
// assumes the host model drives the register port, the bench drives the rest
module tb_top import ssr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, resetn, reg_wr, reg_rd, spi_mode, port_enable_first, loop_unlocked;
    logic control_port_mode, divided_reference, clk_out, aux_level, aux_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    logic [1:0] aux_pin_source_sel;
    logic [31:0] user_ratio;
    logic [2:0] ref_cnt = 3'h0;
    int err_count = 0;
    int n_tests = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // reference period 8 cycles, synthesizer output toggles every cycle
    always @(posedge clk) #1 ref_cnt <= ref_cnt + 3'h1;
    ssr_config_regs uut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .spi_mode(spi_mode),
        .reg_rdata(reg_rdata), .port_enable_first(port_enable_first),
        .aux_pin_source_sel(aux_pin_source_sel), .loop_unlocked(loop_unlocked),
        .reference_in(ref_cnt[2]), .synth_clk(ref_cnt[0]),
        .control_port_mode(control_port_mode), .user_ratio(user_ratio),
        .divided_reference(divided_reference), .clk_out(clk_out), .aux_level(aux_level),
        .aux_oe(aux_oe));
    ssr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .spi_mode(spi_mode), .reg_rdata(reg_rdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic t_regs();
        logic [7:0] a [4] = '{SSR_ADDR_GLOBAL, SSR_ADDR_FUNC1, SSR_ADDR_FUNC2, SSR_ADDR_RATIO0};
        logic [7:0] m [4] = '{8'h01, 8'h58, 8'h10, 8'hFF};
        foreach (a[i]) begin
            host.acc(1'b0, a[i], 8'h00, 1'b0, q);
            chk({24'h0, q}, 32'h0);
            host.acc(1'b1, a[i], m[i], 1'b0, q);
            host.acc(1'b0, a[i], 8'h00, 1'b0, q);
            chk({24'h0, q}, {24'h0, m[i]});
        end
    endtask : t_regs
    task automatic t_ratio();
        logic [7:0] v [4] = '{8'h00, 8'h13, 8'hA9, 8'h2A};
        foreach (v[i]) host.acc(1'b1, SSR_ADDR_RATIO0 + 8'(i), v[i], i[0], q);
        chk(user_ratio, 32'h0013_A92A);
        host.acc(1'b0, SSR_ADDR_RATIO2, 8'h00, 1'b0, q);
        chk({24'h0, q}, 32'hA9);
        host.acc(1'b0, SSR_ADDR_RATIO2, 8'h00, 1'b1, q);
        chk({24'h0, q}, 32'h0);
        host.acc(1'b0, 8'h40, 8'h00, 1'b0, q);
        chk({24'h0, q}, 32'h0);
    endtask : t_ratio
    task automatic t_enable();
        chk(control_port_mode, 0);
        host.acc(1'b1, SSR_ADDR_GLOBAL, 8'h00, 1'b0, q);
        port_enable_first = 1'b1;
        step(1);
        chk(control_port_mode, 0);
        host.acc(1'b1, SSR_ADDR_GLOBAL, 8'h01, 1'b1, q);
        chk(control_port_mode, 1);
        port_enable_first = 1'b0;
        step(1);
        chk(control_port_mode, 0);
        // second enable already set, first one set last
        port_enable_first = 1'b1;
        step(1);
        chk(control_port_mode, 1);
    endtask : t_enable
    task automatic t_aux();
        aux_pin_source_sel = SSR_AUX_LOCK;
        for (int s = 0; s < 2; s++) begin
            host.acc(1'b1, SSR_ADDR_FUNC1, s ? 8'h40 : 8'h00, 1'b0, q);
            for (int u = 0; u < 2; u++) begin
                loop_unlocked = u[0];
                step(3);
                chk({aux_level, aux_oe}, s ? {1'b0, u[0]} : {u[0], 1'b1});
            end
        end
        aux_pin_source_sel = SSR_AUX_SYNTH;
        loop_unlocked = 1'b0;
        step(3);
        chk(aux_oe, 1);
    endtask : t_aux
    task automatic t_clkout();
        int n;
        for (int c = 0; c < 3; c++) begin
            host.acc(1'b1, SSR_ADDR_FUNC2, c == 1 ? 8'h10 : 8'h00, 1'b0, q);
            loop_unlocked = c < 2;
            step(3);
            n = 0;
            repeat (8) begin
                step(1);
                n += int'(clk_out === 1'b1);
            end
            chk(n, c == 0 ? 0 : 4);
        end
    endtask : t_clkout
    // divider period for every prescale code
    task automatic t_prescale();
        int n, last;
        logic p;
        for (int s = 0; s < 4; s++) begin
            host.acc(1'b1, SSR_ADDR_FUNC1, {3'h0, s[1:0], 3'h0}, 1'b0, q);
            step(4);
            n = 0;
            last = -1;
            p = divided_reference;
            for (int c = 0; c < 80; c++) begin
                step(1);
                if (divided_reference === 1'b1 && p === 1'b0) begin
                    n = last < 0 ? 0 : c - last;
                    last = c;
                end
                p = divided_reference;
            end
            chk(n, s == 3 ? 0 : 32 >> s);
        end
    endtask : t_prescale
    // mid-run reset clears the bank, first request right after release
    task automatic t_reset();
        host.acc(1'b1, SSR_ADDR_FUNC2, 8'h10, 1'b0, q);
        resetn = 1'b0;
        step(2);
        resetn = 1'b1;
        chk(user_ratio, 32'h0);
        chk(control_port_mode, 0);
        host.acc(1'b0, SSR_ADDR_FUNC2, 8'h00, 1'b0, q);
        chk({24'h0, q}, 32'h0);
    endtask : t_reset
    initial begin
        resetn = 1'b0;
        port_enable_first = 1'b0;
        aux_pin_source_sel = SSR_AUX_REFDIV;
        loop_unlocked = 1'b0;
        step(16);
        resetn = 1'b1;
        chk(user_ratio, 32'h0);
        t_regs();
        t_ratio();
        t_enable();
        t_aux();
        t_clkout();
        t_prescale();
        t_reset();
        results();
    end
    // a hang is cut short well past the expected run of a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end
endmodule : tb_top
